/* design/fnd_top.sv */
// fnd_top: register file and divider engines for frequency planning
// assumes axi4-lite master on clk, refClk pulses synchronous to clk
`timescale 1ns/1ps
module fnd_top
  import fnd_pkg::*;
#(
  parameter int CAL_CYCLES = 64
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refRise,
  input wire logic refFall,
  input wire logic syncIn,
  input wire logic strapMode,
  input wire logic [18:0] strapNint,
  input wire logic [10:0] strapChdiv,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pdTick,
  output logic fbTick,
  output logic smClkTick,
  output logic calBusy,
  output logic [2:0] outRoute,
  output logic [10:0] chainRatio,
  output logic [3:0] detectorDelaySel,
  output logic sysrefPulse
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    return m;
  endfunction

  function automatic logic [7:0] clampLo(input logic [7:0] v, input logic [7:0] hi);
    logic [7:0] r;
    r = (v == 8'h00) ? 8'h01 : v;
    if (r > hi) r = hi;
    return r;
  endfunction

  // live (software-visible) registers
  logic [31:0] ctrl_r, ref_r, num_r, den_r, out_r;
  logic [18:0] nint_r;
  // active copies used by engines
  logic [31:0] aRef_r, aNum_r, aDen_r, aOut_r;
  logic [18:0] aNint_r;

  // write channel: address and data taken in either order
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wrGo, ctrlWr;
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign wrGo = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign ctrlWr = wrGo && (awAddr_r == ADDR_CTRL);
  logic wrBad;
  assign wrBad = (awAddr_r > ADDR_STAT) || (awAddr_r[1:0] != 2'b00) || (awAddr_r == ADDR_STAT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrGo)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrBad ? 2'b10 : 2'b00;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register store; fields clamped so illegal ranges reach engines only via the unclamped strapChdiv in strap mode
  logic [31:0] wm;
  logic [31:0] mCtrl, mRef, mNum, mDen, mOut;
  assign wm = merge(32'h0000_0000, wData_r, wStrb_r);
  // merged words held as nets, since a function result cannot be sliced
  assign mCtrl = merge(ctrl_r, wData_r, wStrb_r);
  assign mRef = merge(ref_r, wData_r, wStrb_r);
  assign mNum = merge(num_r, wData_r, wStrb_r);
  assign mDen = merge(den_r, wData_r, wStrb_r);
  assign mOut = merge(out_r, wData_r, wStrb_r);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;
      ref_r <= REF_RST;
      nint_r <= NINT_RST;
      num_r <= 32'h0000_0000;
      den_r <= DEN_RST;
      out_r <= OUT_RST;
    end
    else if (wrGo && !wrBad)
    begin
      unique case (awAddr_r)
        ADDR_CTRL:
        begin
          ctrl_r <= mCtrl;
          if (mCtrl[CTRL_ORDER_LSB +: 3] > ORDER_MAX)
            ctrl_r[CTRL_ORDER_LSB +: 3] <= ORDER_MAX;
          if (mCtrl[CTRL_CALDIV_LSB +: 3] > CALDIV_MAX)
            ctrl_r[CTRL_CALDIV_LSB +: 3] <= CALDIV_MAX;
        end
        ADDR_REF:
        begin
          ref_r <= mRef & 32'h00ff_ff01;
          ref_r[REF_PRE_LSB +: 8] <= clampLo(mRef[REF_PRE_LSB +: 8], PRE_MAX);
          ref_r[REF_POST_LSB +: 8] <= clampLo(mRef[REF_POST_LSB +: 8], POST_MAX);
        end
        ADDR_NINT:
        begin
          if (wm[18:0] < NINT_MIN)
            nint_r <= NINT_MIN;
          else
            nint_r <= wm[18:0];
        end
        ADDR_NUM: num_r <= mNum;
        ADDR_DEN: den_r <= (mDen == 32'h0000_0000) ? 32'h0000_0001 : mDen;
        ADDR_OUT:
        begin
          // keeps high-band flag and sysref enables along with the chain ratio
          out_r <= mOut & 32'hfff7_3fff;
          if (mOut[10:0] == 11'h0)
            out_r[10:0] <= 11'h001;
          else if (mOut[10:0] > OUTPUT_CHAIN_DIVIDE_MAX)
            out_r[10:0] <= OUTPUT_CHAIN_DIVIDE_MAX;
        end
        default: ;
      endcase
    end
  end

  // shadow transfer: immediate when disabled, else on control write
  logic applyNow;
  assign applyNow = !ctrl_r[CTRL_SHADOW_BIT] || ctrlWr;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aRef_r <= REF_RST;
      aNint_r <= NINT_RST;
      aNum_r <= 32'h0000_0000;
      aDen_r <= DEN_RST;
      aOut_r <= OUT_RST;
    end
    else if (applyNow)
    begin
      aRef_r <= ref_r;
      // strap mode: integer only, strap divides
      aNint_r <= strapMode ? ((strapNint < NINT_MIN) ? NINT_MIN : strapNint) : nint_r;
      aNum_r <= strapMode ? 32'h0 : num_r;
      aDen_r <= den_r;
      aOut_r <= strapMode ? {out_r[31:11], strapChdiv} : out_r;
    end
  end

  // reference path: doubler picks both edges
  logic refEdge, preTick;
  logic [7:0] preCnt_r, postCnt_r, preLen_r, postLen_r;
  assign refEdge = refRise || (aRef_r[REF_DBL_BIT] && refFall);
  assign preTick = refEdge && (preCnt_r + 8'h01 >= preLen_r);
  // pdTick rate = ref * dbl / (pre * post)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preCnt_r <= 8'h00;
      postCnt_r <= 8'h00;
      preLen_r <= 8'h01;
      postLen_r <= 8'h01;
      pdTick <= 1'b0;
    end
    else
    begin
      pdTick <= 1'b0;
      if (refEdge)
      begin
        if (preTick)
        begin
          preCnt_r <= 8'h00;
          preLen_r <= aRef_r[REF_PRE_LSB +: 8];
          if (postCnt_r + 8'h01 >= postLen_r)
          begin
            postCnt_r <= 8'h00;
            postLen_r <= aRef_r[REF_POST_LSB +: 8];
            pdTick <= 1'b1;
          end
          else
            postCnt_r <= postCnt_r + 8'h01;
        end
        else
          preCnt_r <= preCnt_r + 8'h01;
      end
    end
  end

  // calibration clock divider: divide by 2**exponent
  logic [3:0] smCnt_r;
  logic [3:0] smMask;
  assign smMask = 4'((5'h01 << ctrl_r[CTRL_CALDIV_LSB +: 3]) - 5'h01);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smCnt_r <= 4'h0;
      smClkTick <= 1'b0;
    end
    else
    begin
      smClkTick <= 1'b0;
      if (refRise)
      begin
        smClkTick <= ((smCnt_r & smMask) == smMask);
        smCnt_r <= ((smCnt_r & smMask) == smMask) ? 4'h0 : smCnt_r + 4'h1;
      end
    end
  end

  // calibration runs a fixed number of state-machine ticks
  logic [15:0] calCnt_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      calBusy <= 1'b0;
      calCnt_r <= 16'h0000;
    end
    else if (ctrlWr && wm[CTRL_CAL_BIT])
    begin
      calBusy <= 1'b1;
      calCnt_r <= 16'(CAL_CYCLES);
    end
    else if (calBusy && smClkTick)
    begin
      calCnt_r <= calCnt_r - 16'h0001;
      if (calCnt_r == 16'h0001)
        calBusy <= 1'b0;
    end
  end

  // feedback divider: N + num/den by first-order accumulator per stage
  logic [32:0] acc_r [4];
  logic [2:0] order;
  logic [2:0] carrySum;
  logic [18:0] fbLen_r, fbCnt_r;
  logic [3:0] xCnt_r;
  logic [3:0] xLen;
  assign order = ctrl_r[CTRL_ORDER_LSB +: 3];
  // extra divide only in sync mode
  assign xLen = ctrl_r[CTRL_SYNC_BIT] ? ((aOut_r[OUT_XDIV_LSB +: 4] == 4'h0) ? 4'h1 :
                aOut_r[OUT_XDIV_LSB +: 4]) : 4'h1;
  always_comb
  begin
    carrySum = 3'h0;
    for (int i = 0; i < 4; i++)
      if (i < int'(order) && acc_r[i][32])
        carrySum = carrySum + 3'h1;
  end
  logic fbEnd;
  assign fbEnd = pdTick && (fbCnt_r + 19'h1 >= fbLen_r);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        acc_r[i] <= 33'h0;
      fbLen_r <= NINT_RST;
      fbCnt_r <= 19'h0;
      xCnt_r <= 4'h0;
      fbTick <= 1'b0;
    end
    else if (ctrlWr || syncIn)
    begin
      // repeatable spurs and deterministic sync phase
      for (int i = 0; i < 4; i++)
        acc_r[i] <= 33'h0;
      // restart is a cycle boundary: a stale long ratio must not linger
      fbLen_r <= aNint_r;
      fbCnt_r <= 19'h0;
      xCnt_r <= 4'h0;
      fbTick <= 1'b0;
    end
    else
    begin
      fbTick <= 1'b0;
      if (pdTick)
        fbCnt_r <= fbEnd ? 19'h0 : fbCnt_r + 19'h1;
      if (fbEnd)
      begin
        for (int i = 0; i < 4; i++)
        begin
          logic [32:0] s;
          s = {1'b0, acc_r[i][31:0]} + {1'b0, (i == 0) ? aNum_r : 32'(acc_r[i-1 < 0 ? 0 : i-1][32])};
          acc_r[i] <= (s >= {1'b0, aDen_r}) ? {1'b1, 32'(s - {1'b0, aDen_r})} : s;
        end
        // order zero: no carries, integer divide
        fbLen_r <= aNint_r + 19'(carrySum);
        xCnt_r <= (xCnt_r + 4'h1 >= xLen) ? 4'h0 : xCnt_r + 4'h1;
        fbTick <= (xCnt_r + 4'h1 >= xLen);
      end
    end
  end

  // output routing by band select; chain limited to 6 at high band
  always_comb
  begin
    unique case (aOut_r[OUT_SEL_LSB +: 3])
      3'b010: outRoute = OSEL_VCO;
      3'b100: outRoute = OSEL_DBL;
      default: outRoute = OSEL_CHAIN;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chainRatio <= 11'h001;
      detectorDelaySel <= 4'h1;
    end
    else
    begin
      if (aOut_r[11] && aOut_r[10:0] > OUTPUT_CHAIN_DIVIDE_HI_MAX)
        chainRatio <= OUTPUT_CHAIN_DIVIDE_HI_MAX;
      else
        chainRatio <= aOut_r[10:0];
      detectorDelaySel <= ctrl_r[CTRL_DLY_LSB +: 4];
    end
  end

  // sysref: repeating train, one pulse per (delay count + 1) fb ticks from sync
  logic [7:0] srCnt_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srCnt_r <= 8'h00;
      sysrefPulse <= 1'b0;
    end
    else
    begin
      sysrefPulse <= 1'b0;
      if (syncIn)
        srCnt_r <= aOut_r[31:24];
      else if (fbTick && aOut_r[13:12] != 2'b00)
      begin
        if (srCnt_r == 8'h00)
        begin
          sysrefPulse <= 1'b1;
          srCnt_r <= aOut_r[31:24];
        end
        else
          srCnt_r <= srCnt_r - 8'h01;
      end
    end
  end

  // read channel
  logic [7:0] rA;
  assign rA = s_axi_araddr[7:0];
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (rA)
        ADDR_CTRL: s_axi_rdata <= ctrl_r;
        ADDR_REF: s_axi_rdata <= ref_r;
        ADDR_NINT: s_axi_rdata <= {13'h0, nint_r};
        ADDR_NUM: s_axi_rdata <= num_r;
        ADDR_DEN: s_axi_rdata <= den_r;
        ADDR_OUT: s_axi_rdata <= out_r;
        ADDR_STAT: s_axi_rdata <= {24'h0, outRoute, strapMode, 3'h0, calBusy};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  AST_CAL_START: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrlWr && wm[CTRL_CAL_BIT]) |=> calBusy) else $error("cal not started");
  AST_ORDER_MAX: assert property (@(posedge clk) disable iff (!rst_n)
    order <= ORDER_MAX) else $error("order out of range");
  AST_DEN_NZ: assert property (@(posedge clk) disable iff (!rst_n)
    den_r != 32'h0) else $error("zero denominator");
  AST_NINT_MIN: assert property (@(posedge clk) disable iff (!rst_n)
    aNint_r >= NINT_MIN) else $error("n below minimum");
  AST_MOD_RST: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlWr |=> (acc_r[0] == 33'h0)) else $error("modulator not reset");
  AST_INT_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    (order == 3'h0 && fbEnd && !ctrlWr && !syncIn) |=> fbLen_r == $past(aNint_r))
    else $error("integer mode not integer");
  AST_XDIV_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_r[CTRL_SYNC_BIT] |-> xLen == 4'h1) else $error("extra divide outside sync");
  AST_CHAIN_MAX: assert property (@(posedge clk) disable iff (!rst_n)
    chainRatio <= OUTPUT_CHAIN_DIVIDE_MAX && chainRatio != 11'h0) else $error("chain ratio range");
  AST_SHADOW: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[CTRL_SHADOW_BIT] && !ctrlWr) |=> $stable(aNum_r)) else $error("shadow leak");
endmodule

/* pkg/fnd_pkg.sv */
// fnd_pkg: constants for the fractional-n divider control block
// assumes a 32-bit axi4-lite register bus and a single clock domain
package fnd_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF = 8'h04;
  localparam logic [7:0] ADDR_NINT = 8'h08;
  localparam logic [7:0] ADDR_NUM = 8'h0c;
  localparam logic [7:0] ADDR_DEN = 8'h10;
  localparam logic [7:0] ADDR_OUT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  // ctrl field positions
  localparam int CTRL_CAL_BIT = 0;
  localparam int CTRL_SHADOW_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_ORDER_LSB = 4;
  localparam int CTRL_CALDIV_LSB = 8;
  localparam int CTRL_DLY_LSB = 12;
  // ref and out field positions
  localparam int REF_DBL_BIT = 0;
  localparam int REF_PRE_LSB = 8;
  localparam int REF_POST_LSB = 16;
  localparam int OUT_SEL_LSB = 16;
  localparam int OUT_XDIV_LSB = 20;
  // limits
  localparam logic [2:0] ORDER_MAX = 3'h4;
  localparam logic [7:0] PRE_MAX = 8'h80;
  localparam logic [7:0] POST_MAX = 8'hff;
  localparam logic [18:0] NINT_MIN = 19'h0001c;
  localparam logic [18:0] NINT_MAX = 19'h7ffff;
  localparam logic [10:0] OUTPUT_CHAIN_DIVIDE_MAX = 11'h600;
  localparam logic [10:0] OUTPUT_CHAIN_DIVIDE_HI_MAX = 11'h006;
  localparam logic [2:0] CALDIV_MAX = 3'h4;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_1000;
  localparam logic [31:0] REF_RST = 32'h0001_0100;
  localparam logic [18:0] NINT_RST = 19'h00064;
  localparam logic [31:0] DEN_RST = 32'h0000_0001;
  localparam logic [31:0] OUT_RST = 32'h0011_0001;
  typedef enum logic [2:0] {
    OSEL_CHAIN = 3'b001,
    OSEL_VCO = 3'b010,
    OSEL_DBL = 3'b100
  } fnd_osel_type;
endpackage

/* verif/fnd_ref_src.sv */
// fnd_ref_src: reference source as one-cycle edge pulses on clk
// assumes clk runs several times faster than the reference
`timescale 1ns/1ps
module fnd_ref_src
#(
  parameter int PERIOD = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  output logic refRise,
  output logic refFall
);
  int ph;
  // free-running at 50% duty, present before any calibration
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph <= 0;
      refRise <= 1'b0;
      refFall <= 1'b0;
    end
    else
    begin
      ph <= (ph == PERIOD - 1) ? 0 : ph + 1;
      refRise <= (ph == 0);
      refFall <= (ph == PERIOD / 2);
    end
  end
endmodule

/* verif/test_fnd_top.sv */
// test_fnd_top: self-checking bench for the divider control block
// assumes fnd_ref_src gives one reference period every 8 clk cycles
`timescale 1ns/1ps
module test_fnd_top;
  import fnd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic syncIn = 1'b0;
  logic strapMode = 1'b0;
  logic [18:0] strapNint = 19'h00000;
  logic [10:0] strapChdiv = 11'h000;
  logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, refRise, refFall;
  logic [1:0] bResp, rResp;
  logic pdTick, fbTick, smTick, calBusy, sysref;
  logic [2:0] route;
  logic [10:0] chain;
  logic [3:0] dly;
  int failCount = 0;
  int testsRun = 0;

  always #25 clk = ~clk;

  fnd_ref_src i_ref (.clk(clk), .rst_n(rst_n), .refRise(refRise), .refFall(refFall));

  fnd_top #(.CAL_CYCLES(4)) i_dut (
    .clk(clk), .rst_n(rst_n), .refRise(refRise), .refFall(refFall), .syncIn(syncIn),
    .strapMode(strapMode), .strapNint(strapNint), .strapChdiv(strapChdiv),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pdTick(pdTick), .fbTick(fbTick), .smClkTick(smTick), .calBusy(calBusy),
    .outRoute(route), .chainRatio(chain), .detectorDelaySel(dly), .sysrefPulse(sysref));

  task automatic tallyAndFinish();
    if (failCount == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chkV(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e)
    begin
      failCount++;
      $display("unexpected value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkR(input logic [1:0] g, input logic [1:0] e);
    testsRun++;
    if (g !== e)
    begin
      failCount++;
      $display("unexpected resp at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // aw and w offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad = 0;
    bit dd = 0;
    @(posedge clk);
    awAddr <= {24'h000000, a};
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (awReady && !ad)
      begin
        ad = 1;
        awValid <= 1'b0;
      end
      if (wReady && !dd)
      begin
        dd = 1;
        wValid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bValid);
    r = bResp;
    bReady <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arAddr <= {24'h000000, a};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge clk); while (!rValid);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask

  task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chkR(r, 2'h0);
    repeat (3) @(posedge clk);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chkR(r, 2'h0);
    chkV(d, e);
  endtask

  // cycles between two ticks, skipping the interval after a change
  task automatic per(input int sel, output logic [31:0] c);
    c = 32'h0;
    repeat (2)
      do @(posedge clk); while (!((sel == 2) ? fbTick : (sel == 1) ? smTick : pdTick));
    do
    begin
      @(posedge clk);
      c++;
    end
    while (!((sel == 2) ? fbTick : (sel == 1) ? smTick : pdTick));
  endtask

  task automatic t_fb();
    logic [31:0] c1;
    logic [31:0] c2;
    wrOk(ADDR_NINT, 32'h1c);
    wrOk(ADDR_CTRL, 32'h1000);
    per(2, c1);
    chkV(c1, 32'he0);
    wrOk(ADDR_NUM, 32'h1);
    wrOk(ADDR_DEN, 32'h2);
    wrOk(ADDR_CTRL, 32'h1010);
    per(2, c1);
    per(2, c2);
    chkV(c1 + c2, 32'h1c8);
  endtask

  // sysref every third feedback tick after a sync pulse
  task automatic t_sysref();
    int n = 0;
    int k = 0;
    wrOk(ADDR_OUT, 32'h02011001);
    syncIn <= 1'b1;
    @(posedge clk);
    syncIn <= 1'b0;
    @(posedge clk);
    while (!sysref && k < 2000)
    begin
      @(posedge clk);
      if (fbTick) n++;
      k++;
    end
    chkV(n, 32'h3);
    wrOk(ADDR_CTRL, 32'h1000);
    wrOk(ADDR_OUT, 32'h00010001);
  endtask

  task automatic t_reset();
    chkV({21'h0, chain}, 32'h1);
    chkV({28'h0, dly}, 32'h1);
    chkV({29'h0, route}, 32'h1);
    rdChk(ADDR_CTRL, CTRL_RST);
    rdChk(ADDR_REF, REF_RST);
    rdChk(ADDR_NINT, {13'h0, NINT_RST});
    rdChk(ADDR_DEN, DEN_RST);
    rdChk(ADDR_OUT, OUT_RST);
  endtask

  task automatic t_fields();
    logic [2:0] o [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [1:0] r;
    logic [31:0] d;
    foreach (o[i])
    begin
      wrOk(ADDR_CTRL, 32'h1000 | (o[i] << CTRL_ORDER_LSB));
      rdChk(ADDR_CTRL, 32'h1000 | ((o[i] > 3'h4 ? 3'h4 : o[i]) << CTRL_ORDER_LSB));
    end
    wrOk(ADDR_NINT, 32'h5);
    rdChk(ADDR_NINT, 32'h1c);
    wrOk(ADDR_NINT, 32'h7ffff);
    rdChk(ADDR_NINT, 32'h7ffff);
    wrOk(ADDR_DEN, 32'h0);
    rdChk(ADDR_DEN, 32'h1);
    wrOk(ADDR_DEN, 32'hffffffff);
    rdChk(ADDR_DEN, 32'hffffffff);
    wr(8'h40, 32'h1, r);
    chkR(r, 2'h2);
    wr(ADDR_STAT, 32'h1, r);
    chkR(r, 2'h2);
    rd(8'h40, d, r);
    chkR(r, 2'h2);
    chkV(d, 32'h0);
  endtask

  task automatic t_ref();
    logic [31:0] w [8] = '{32'h00010100, 32'h00010101, 32'h00030100, 32'h00030101,
                           32'h00030200, 32'h00018000, 32'h00ff0101, 32'h00000100};
    logic [31:0] e [8] = '{8, 4, 24, 12, 48, 1024, 1020, 8};
    logic [31:0] c;
    foreach (w[i])
    begin
      wrOk(ADDR_REF, w[i]);
      per(1'b0, c);
      chkV(c, e[i]);
    end
  endtask

  task automatic t_sm();
    logic [2:0] x [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [31:0] c;
    foreach (x[i])
    begin
      wrOk(ADDR_CTRL, 32'h1000 | (x[i] << CTRL_CALDIV_LSB));
      per(1'b1, c);
      chkV(c, 32'h8 << (x[i] > 3'h4 ? 3'h4 : x[i]));
    end
    wrOk(ADDR_CTRL, 32'h1000);
  endtask

  task automatic t_cal();
    logic [31:0] d;
    logic [1:0] r;
    int n = 0;
    repeat (10) @(posedge clk);
    chkV({31'h0, calBusy}, 32'h0);
    wrOk(ADDR_CTRL, 32'h1001);
    chkV({31'h0, calBusy}, 32'h1);
    rd(ADDR_STAT, d, r);
    chkV({31'h0, d[0]}, 32'h1);
    while (calBusy && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chkV({31'h0, calBusy}, 32'h0);
  endtask

  task automatic t_out();
    wrOk(ADDR_OUT, 32'h00010600);
    chkV({21'h0, chain}, 32'h600);
    wrOk(ADDR_OUT, 32'h0001080c);
    chkV({21'h0, chain}, 32'h6);
    for (int i = 0; i < 3; i++)
    begin
      wrOk(ADDR_OUT, (32'h1 << (OUT_SEL_LSB + i)) | 32'h1);
      chkV({29'h0, route}, 32'h1 << i);
    end
    // shadowed: chain waits for the next control write; delay is unshadowed and comes from that write itself
    wrOk(ADDR_CTRL, 32'h1002);
    wrOk(ADDR_OUT, 32'h0001000c);
    chkV({21'h0, chain}, 32'h1);
    wrOk(ADDR_CTRL, 32'h6002);
    chkV({21'h0, chain}, 32'hc);
    chkV({28'h0, dly}, 32'h6);
    wrOk(ADDR_CTRL, 32'h1000);
    wrOk(ADDR_OUT, 32'h00010001);
  endtask

  task automatic t_strap();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    strapChdiv <= 11'h005;
    strapNint <= 19'h00028;
    strapMode <= 1'b1;
    syncIn <= 1'b1;
    @(posedge clk);
    syncIn <= 1'b0;
    repeat (3) @(posedge clk);
    chkV({21'h0, chain}, 32'h5);
    rd(ADDR_STAT, d, r);
    chkV({31'h0, d[4]}, 32'h1);
    strapMode <= 1'b0;
    repeat (3) @(posedge clk);
    chkV({21'h0, chain}, 32'h1);
  endtask

  initial
  begin
    #2000000;
    failCount++;
    tallyAndFinish();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_ref();
    t_sm();
    t_cal();
    t_out();
    t_fb();
    t_sysref();
    t_strap();
    tallyAndFinish();
  end
endmodule
